// ==== logic/rg_pkg.sv ====
// Notes on behaviour
// - Enable clear: ignore controls, stop clocks
// - Destination field routes ramp to one parameter
// - Output MSB-aligned, unused low bits dropped
// - Direction low falls, direction high rises
// - Freeze pin high stalls ramp at last state
// - Unselected parameters come from active profile
// - Accumulator stepped by timer on DDS clock
// - Step interval is 24 clocks times count, a count of zero acting as one
// - Falling step is subtracted, both unsigned
// - Phase gets 16 bits, amplitude 12 bits
// - Timer reloads on enable, direction, rate-reload
// - Output within settled limits while enabled, unless lower exceeds upper
// - Clear sets accumulator zero, output lower
// - Enable, clear, autoclear act at update only
// - Enable: rise if direction high, else lower
// - At a limit stay until direction or limit
// - Autoclear clears for one DDS clock only
package rg_pkg;
    localparam int unsigned DDS_DIV      = 24;
    localparam logic [4:0]  DIV_LAST     = 5'(DDS_DIV - 1);
    localparam logic [5:0]  IDX_CTRL     = 6'h00;
    localparam logic [5:0]  IDX_RISE     = 6'h06;
    localparam logic [5:0]  IDX_FALL     = 6'h07;
    localparam logic [5:0]  IDX_RATE     = 6'h08;
    localparam logic [5:0]  IDX_LOWER    = 6'h09;
    localparam logic [5:0]  IDX_UPPER    = 6'h0a;
    localparam logic [5:0]  IDX_UPDATE   = 6'h0b;
    localparam logic [5:0]  IDX_STATUS   = 6'h0c;
    localparam int unsigned CTRL_EN_POS  = 0;
    localparam int unsigned CTRL_CLR_POS = 1;
    localparam int unsigned CTRL_ACL_POS = 2;
    localparam int unsigned CTRL_LRR_POS = 3;
    localparam int unsigned CTRL_DST_POS = 4;
    localparam int unsigned RATE_P_POS   = 16;
    localparam int unsigned RATE_N_POS   = 0;
    localparam logic [31:0] CTRL_MASK    = 32'h0000_003f;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam logic [31:0] STEP_RST     = 32'h0000_0000;
    localparam logic [31:0] RATE_RST     = 32'h0001_0001;
    localparam logic [31:0] LOWER_RST    = 32'h0000_0000;
    localparam logic [31:0] UPPER_RST    = 32'hffff_ffff;
    localparam logic [1:0]  DEST_FREQ    = 2'h0;
    localparam logic [1:0]  DEST_PHASE   = 2'h1;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    typedef struct packed {
        logic [31:0] freq;
        logic [15:0] phase;
        logic [11:0] amp;
    } rg_dds_t;

    typedef struct packed {
        logic [1:0] dest;
        logic       ramp_rate_reload;
        logic       aclr;
        logic       clr;
        logic       en;
    } rg_ctrl_t;
endpackage : rg_pkg

// ==== logic/rg_pin_sync.sv ====
`timescale 1ns/100ps
module rg_pin_sync (
    input  logic clk,    // System clock
    input  logic rst_n,  // Synchronous reset, active low
    input  logic ce,     // Clock enable
    input  logic pin,    // Asynchronous pin
    output logic level   // Filtered level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // The first stage feeds only the second, so metastability stays contained
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level  <= 1'b0;
        end else if (ce) begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule : rg_pin_sync

// ==== logic/rg_step_timer.sv ====
`timescale 1ns/100ps
module rg_step_timer #(
    parameter int unsigned W = 16
) (
    input  logic         clk,     // System clock
    input  logic         rst_n,   // Synchronous reset, active low
    input  logic         ce,      // Clock enable
    input  logic         tick,    // DDS clock tick, already gated by freeze
    input  logic         reload,  // Restart the interval
    input  logic [W-1:0] value,   // Interval count of the current slope
    output logic         expire   // Step due in this cycle
);
    logic [W-1:0] cnt_reg;

    // A count of zero behaves as one: a step on every DDS tick
    assign expire = tick && !reload && (cnt_reg <= W'(1));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= '0;
        end else if (ce) begin
            if (reload || expire) begin
                cnt_reg <= value;
            end else if (tick) begin
                cnt_reg <= cnt_reg - W'(1);
            end
        end
    end

    AST_TMR_RELOAD: assert property (@(posedge clk) disable iff (!rst_n)
        ce && reload |=> cnt_reg == $past(value))
        else $error("timer not reloaded");
    AST_TMR_COUNT: assert property (@(posedge clk) disable iff (!rst_n)
        ce && tick && !reload && cnt_reg > W'(1) |=> cnt_reg == $past(cnt_reg) - W'(1))
        else $error("timer did not count down");
endmodule : rg_step_timer

// ==== logic/rg_ramp_generator.sv ====
`timescale 1ns/100ps
module rg_ramp_generator (
    input  logic           clk,                 // System clock, 25 MHz
    input  logic           rst_n,               // Synchronous reset, active low
    input  logic           ce,                  // Clock enable, freezes all state
    input  logic [7:0]     awaddr,              // Write address
    input  logic           awvalid,             // Write address valid
    output logic           awready,             // Write address ready
    input  logic [31:0]    wdata,               // Write data
    input  logic [3:0]     wstrb,               // Write byte strobes
    input  logic           wvalid,              // Write data valid
    output logic           wready,              // Write data ready
    output logic [1:0]     bresp,               // Write response
    output logic           bvalid,              // Write response valid
    input  logic           bready,              // Write response ready
    input  logic [7:0]     araddr,              // Read address
    input  logic           arvalid,             // Read address valid
    output logic           arready,             // Read address ready
    output logic [31:0]    rdata,               // Read data
    output logic [1:0]     rresp,               // Read response
    output logic           rvalid,              // Read data valid
    input  logic           rready,              // Read data ready
    input  logic           ramp_direction_pin,  // High rises, low falls
    input  logic           ramp_freeze_pin,     // High stalls the ramp
    input  rg_pkg::rg_dds_t prof_in,            // Active profile parameters
    output rg_pkg::rg_dds_t dds_out,            // Parameters to the DDS core
    output logic [31:0]    ramp_out             // Limited ramp value
);
    logic            aw_ok_reg;
    logic            w_ok_reg;
    logic            b_reg;
    logic [5:0]      waddr_reg;
    logic [31:0]     wdata_reg;
    logic [3:0]      wstrb_reg;
    logic [1:0]      bresp_reg;
    logic            ar_ok_reg;
    logic            r_reg;
    logic [31:0]     rdata_reg;
    logic [1:0]      rresp_reg;
    logic            do_write;
    logic [31:0]     ctrl_reg;
    logic [31:0]     rise_reg;
    logic [31:0]     fall_reg;
    logic [31:0]     rate_reg;
    logic [31:0]     lower_reg;
    logic [31:0]     upper_reg;
    logic            upd_reg;
    rg_pkg::rg_ctrl_t sh;
    rg_pkg::rg_ctrl_t act_reg;
    logic            en_rise;
    logic [4:0]      presc_reg;
    logic            dds_tick;
    logic            dir_s;
    logic            hold_s;
    logic            dir_prev_reg;
    logic            dir_chg;
    logic            reload_req;
    logic [15:0]     interval;
    logic            step_exp;
    logic [31:0]     acc_reg;
    logic            aclr_pend_reg;
    logic [31:0]     acc_lim;
    logic [32:0]     up_sum;
    logic [31:0]     up_next;
    logic [31:0]     dn_next;
    logic [31:0]     ramp_reg;
    rg_pkg::rg_dds_t dds_reg;

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge

    // Limit stage sits in the feedback path, so every value leaving it is in range unless lower exceeds upper
    function automatic logic [31:0] clamp(input logic [31:0] v,
                                          input logic [31:0] lo,
                                          input logic [31:0] hi);
        logic [31:0] res;
        res = v;
        if (v < lo) begin
            res = lo;
        end else if (v > hi) begin
            res = hi;
        end
        return res;
    endfunction : clamp

    assign awready  = aw_ok_reg;
    assign wready   = w_ok_reg;
    assign bvalid   = b_reg;
    assign bresp    = bresp_reg;
    assign arready  = ar_ok_reg;
    assign rvalid   = r_reg;
    assign rdata    = rdata_reg;
    assign rresp    = rresp_reg;
    assign ramp_out = ramp_reg;
    assign dds_out  = dds_reg;
    assign do_write = !aw_ok_reg && !w_ok_reg && !b_reg;

    // Address and data are latched independently, so either may come first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aw_ok_reg <= 1'b1;
            w_ok_reg  <= 1'b1;
            b_reg     <= 1'b0;
            waddr_reg <= 6'h00;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else if (ce) begin
            if (aw_ok_reg && awvalid) begin
                aw_ok_reg <= 1'b0;
                waddr_reg <= awaddr[7:2];
            end
            if (w_ok_reg && wvalid) begin
                w_ok_reg  <= 1'b0;
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (do_write) begin
                b_reg <= 1'b1;
            end
            if (b_reg && bready) begin
                b_reg     <= 1'b0;
                aw_ok_reg <= 1'b1;
                w_ok_reg  <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg  <= rg_pkg::CTRL_RST;
            rise_reg  <= rg_pkg::STEP_RST;
            fall_reg  <= rg_pkg::STEP_RST;
            rate_reg  <= rg_pkg::RATE_RST;
            lower_reg <= rg_pkg::LOWER_RST;
            upper_reg <= rg_pkg::UPPER_RST;
            upd_reg   <= 1'b0;
            bresp_reg <= rg_pkg::RESP_OKAY;
        end else if (ce) begin
            upd_reg <= 1'b0;
            if (do_write) begin
                bresp_reg <= rg_pkg::RESP_OKAY;
                unique case (waddr_reg)
                    rg_pkg::IDX_CTRL: begin
                        ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) & rg_pkg::CTRL_MASK;
                    end
                    rg_pkg::IDX_RISE:  rise_reg  <= merge(rise_reg, wdata_reg, wstrb_reg);
                    rg_pkg::IDX_FALL:  fall_reg  <= merge(fall_reg, wdata_reg, wstrb_reg);
                    rg_pkg::IDX_RATE:  rate_reg  <= merge(rate_reg, wdata_reg, wstrb_reg);
                    rg_pkg::IDX_LOWER: lower_reg <= merge(lower_reg, wdata_reg, wstrb_reg);
                    rg_pkg::IDX_UPPER: upper_reg <= merge(upper_reg, wdata_reg, wstrb_reg);
                    rg_pkg::IDX_UPDATE: upd_reg  <= wdata_reg[0] && wstrb_reg[0];
                    default: bresp_reg <= rg_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ar_ok_reg <= 1'b1;
            r_reg     <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= rg_pkg::RESP_OKAY;
        end else if (ce) begin
            if (ar_ok_reg && arvalid) begin
                ar_ok_reg <= 1'b0;
                r_reg     <= 1'b1;
                rresp_reg <= rg_pkg::RESP_OKAY;
                unique case (araddr[7:2])
                    rg_pkg::IDX_CTRL:   rdata_reg <= ctrl_reg;
                    rg_pkg::IDX_RISE:   rdata_reg <= rise_reg;
                    rg_pkg::IDX_FALL:   rdata_reg <= fall_reg;
                    rg_pkg::IDX_RATE:   rdata_reg <= rate_reg;
                    rg_pkg::IDX_LOWER:  rdata_reg <= lower_reg;
                    rg_pkg::IDX_UPPER:  rdata_reg <= upper_reg;
                    rg_pkg::IDX_UPDATE: rdata_reg <= 32'h0000_0000;
                    rg_pkg::IDX_STATUS: rdata_reg <= acc_lim;
                    default: begin
                        rdata_reg <= 32'h0000_0000;
                        rresp_reg <= rg_pkg::RESP_SLVERR;
                    end
                endcase
            end
            if (r_reg && rready) begin
                r_reg     <= 1'b0;
                ar_ok_reg <= 1'b1;
            end
        end
    end

    always_comb begin
        sh.en   = ctrl_reg[rg_pkg::CTRL_EN_POS];
        sh.clr  = ctrl_reg[rg_pkg::CTRL_CLR_POS];
        sh.aclr = ctrl_reg[rg_pkg::CTRL_ACL_POS];
        sh.ramp_rate_reload  = ctrl_reg[rg_pkg::CTRL_LRR_POS];
        sh.dest = ctrl_reg[rg_pkg::CTRL_DST_POS +: 2];
    end

    // Software may stage several control bits and apply them together
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            act_reg <= '0;
        end else if (ce && upd_reg) begin
            act_reg <= sh;
        end
    end

    assign en_rise = upd_reg && sh.en && !act_reg.en;

    // DDS clock stands still while disabled, which is where the power goes
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            presc_reg <= 5'h00;
        end else if (ce) begin
            if (!act_reg.en) begin
                presc_reg <= 5'h00;
            end else if (presc_reg == rg_pkg::DIV_LAST) begin
                presc_reg <= 5'h00;
            end else begin
                presc_reg <= presc_reg + 5'h01;
            end
        end
    end

    assign dds_tick = act_reg.en && (presc_reg == rg_pkg::DIV_LAST);

    rg_pin_sync u_dir_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (ramp_direction_pin),
        .level (dir_s)
    );

    rg_pin_sync u_hold_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .pin   (ramp_freeze_pin),
        .level (hold_s)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dir_prev_reg <= 1'b0;
        end else if (ce) begin
            dir_prev_reg <= dir_s;
        end
    end

    assign dir_chg    = act_reg.en && (dir_s != dir_prev_reg);
    assign reload_req = en_rise || dir_chg || (upd_reg && sh.en && sh.ramp_rate_reload);
    assign interval   = dir_s ? rate_reg[rg_pkg::RATE_P_POS +: 16]
                              : rate_reg[rg_pkg::RATE_N_POS +: 16];

    rg_step_timer #(
        .W (16)
    ) u_timer (
        .clk    (clk),
        .rst_n  (rst_n),
        .ce     (ce),
        .tick   (dds_tick && !hold_s),
        .reload (reload_req),
        .value  (interval),
        .expire (step_exp)
    );

    // A limit reached simply saturates; moving the limit out lets steps pass again
    assign acc_lim = clamp(acc_reg, lower_reg, upper_reg);
    assign up_sum  = {1'b0, acc_lim} + {1'b0, rise_reg};
    assign up_next = up_sum[32] ? upper_reg : clamp(up_sum[31:0], lower_reg, upper_reg);
    assign dn_next = (acc_lim < fall_reg) ? lower_reg
                   : clamp(acc_lim - fall_reg, lower_reg, upper_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            aclr_pend_reg <= 1'b0;
        end else if (ce) begin
            if (upd_reg && sh.en && sh.aclr) begin
                aclr_pend_reg <= 1'b1;
            end else if (dds_tick) begin
                aclr_pend_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_reg <= 32'h0000_0000;
        end else if (ce) begin
            if (act_reg.en && (act_reg.clr || aclr_pend_reg)) begin
                acc_reg <= 32'h0000_0000;
            end else if (en_rise && !dir_s) begin
                acc_reg <= 32'h0000_0000;
            end else if (step_exp) begin
                acc_reg <= dir_s ? up_next : dn_next;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramp_reg <= 32'h0000_0000;
            dds_reg  <= '0;
        end else if (ce) begin
            ramp_reg      <= acc_lim;
            dds_reg.freq  <= prof_in.freq;
            dds_reg.phase <= prof_in.phase;
            dds_reg.amp   <= prof_in.amp;
            if (act_reg.en) begin
                if (act_reg.dest[1]) begin
                    dds_reg.amp <= acc_lim[31:20];
                end else if (act_reg.dest == rg_pkg::DEST_PHASE) begin
                    dds_reg.phase <= acc_lim[31:16];
                end else begin
                    dds_reg.freq <= acc_lim;
                end
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_OFF_NO_TICK: assert property (ce && !act_reg.en
        |=> presc_reg == 5'h00 && !step_exp)
        else $error("ramp runs while disabled");
    AST_DEST_AMP: assert property (ce && act_reg.en && act_reg.dest[1]
        |=> dds_out.amp == ramp_out[31:20] && dds_out.freq == $past(prof_in.freq))
        else $error("amplitude routing wrong");
    AST_UP_STEP: assert property (ce && step_exp && dir_s && !act_reg.clr
        && !aclr_pend_reg |=> acc_reg == $past(up_next))
        else $error("rising step not applied");
    AST_DN_STEP: assert property (ce && step_exp && !dir_s && !act_reg.clr
        && !aclr_pend_reg |=> acc_reg == $past(dn_next))
        else $error("falling step not applied");
    AST_HOLD: assert property (hold_s && ce && !act_reg.clr && !aclr_pend_reg
        && !en_rise |=> $stable(acc_reg))
        else $error("ramp moved under freeze");
    AST_LIMITS: assert property (act_reg.en && $past(ce) && $stable(lower_reg)
        && $stable(upper_reg) && lower_reg < upper_reg
        |-> ramp_out >= lower_reg && ramp_out <= upper_reg)
        else $error("ramp outside limits");
    AST_CLEAR: assert property (ce && act_reg.en && act_reg.clr
        |=> acc_reg == 32'h0000_0000 ##1 ramp_out == lower_reg || !$stable(lower_reg))
        else $error("clear did not force lower limit");
    AST_UPDATE_ONLY: assert property (!upd_reg |=> $stable(act_reg))
        else $error("control changed without update");
    AST_ENABLE_LOW: assert property (ce && en_rise && !dir_s
        |=> acc_reg == 32'h0000_0000 && act_reg.en)
        else $error("enable did not start at lower limit");
    AST_ACLR_ONCE: assert property (ce && aclr_pend_reg && dds_tick
        && !upd_reg |=> !aclr_pend_reg && acc_reg == 32'h0000_0000)
        else $error("autoclear not single cycle");
    AST_DIR_RELOAD: assert property (ce && dir_chg
        |=> u_timer.cnt_reg == $past(interval))
        else $error("direction change did not reload timer");

    COV_UP_STEP: cover property (step_exp && dir_s);
    COV_DN_STEP: cover property (step_exp && !dir_s);
    COV_HOLD:    cover property (hold_s && dds_tick);
    COV_ACLR:    cover property (aclr_pend_reg && dds_tick);
endmodule : rg_ramp_generator

// ==== bench/rg_far_end.sv ====
`timescale 1ns/100ps
module rg_far_end (
    input  logic            clk,      // System clock
    input  logic            dir_req,  // Wanted slope, high rises
    input  logic            hold_req, // Wanted freeze
    input  rg_pkg::rg_dds_t prof_req, // Wanted profile
    output logic            dir_pin,  // Direction pin level
    output logic            hold_pin, // Freeze pin level
    output rg_pkg::rg_dds_t prof      // Active profile
);
    // Pins move just after an edge, as an external controller would
    always @(posedge clk) begin
        dir_pin  <= dir_req;
        hold_pin <= hold_req;
        prof     <= prof_req;
    end
endmodule : rg_far_end

// ==== bench/tb.sv ====
`timescale 1ns/100ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    logic            clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic            arvalid = 0, rready = 0, dir = 0, hold = 0, ce = 1;
    logic [7:0]      awaddr = 0, araddr = 0;
    logic [31:0]     wdata = 0, v, ramp_out;
    logic [3:0]      wstrb = 0;
    logic [1:0]      r;
    logic            awready, wready, bvalid, arready, rvalid, dpin, hpin;
    logic [1:0]      bresp, rresp;
    logic [31:0]     rdata, dlt;
    logic [63:0]     r64;
    rg_pkg::rg_dds_t prof_req, prof, dds_out;
    int              mismatches = 0, tests_run = 0, gap, seed;

    always #20 clk = ~clk;

    rg_far_end far (.clk(clk), .dir_req(dir), .hold_req(hold), .prof_req(prof_req),
                    .dir_pin(dpin), .hold_pin(hpin), .prof(prof));
    rg_ramp_generator uut (.clk(clk), .rst_n(rst_n), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .ramp_direction_pin(dpin), .ramp_freeze_pin(hpin), .prof_in(prof),
        .dds_out(dds_out), .ramp_out(ramp_out));

    function automatic logic [7:0] a(input logic [5:0] idx);
        a = {idx, 2'b00};
    endfunction : a

    function automatic rg_pkg::rg_dds_t exp_dds(input logic [1:0] d, input logic [31:0] x,
                                                input rg_pkg::rg_dds_t p);
        exp_dds = p;
        if (d == rg_pkg::DEST_FREQ) exp_dds.freq = x;
        else if (d == rg_pkg::DEST_PHASE) exp_dds.phase = x[31:16];
        else exp_dds.amp = x[31:20];
    endfunction : exp_dds

    // A wait whose response never comes ends only through the watchdog; one idle edge keeps back-to-back calls apart
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        awaddr <= a(idx); wdata <= d; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
        end while (bvalid !== 1'b1);
        bready <= 0; r = bresp;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [5:0] idx);
        araddr <= a(idx); arvalid <= 1; rready <= 1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 0;
        end while (rvalid !== 1'b1);
        rready <= 0; v = rdata; r = rresp;
        @(posedge clk);
    endtask : rd

    task automatic upd();
        wr(rg_pkg::IDX_UPDATE, 32'h0000_0001);
    endtask : upd

    // Gap in cycles and size of the next change of the ramp output
    task automatic step();
        logic [31:0] p;
        p = ramp_out; gap = 0;
        do begin
            @(posedge clk); gap++;
        end while (ramp_out === p);
        dlt = ramp_out - p;
    endtask : step

    task automatic conclude();
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    initial begin
        repeat (60000) @(posedge clk);
        mismatches++;
        conclude();
    end

    initial begin
        seed = $urandom(32'h66534645);
        r64 = {$urandom, $urandom};
        prof_req = r64[59:0];
        repeat (5) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        rd(rg_pkg::IDX_RATE); `CHK(v, rg_pkg::RATE_RST)
        rd(rg_pkg::IDX_UPPER); `CHK(v, rg_pkg::UPPER_RST)
        rd(rg_pkg::IDX_CTRL); `CHK(v, rg_pkg::CTRL_RST)
        rd(6'h0f); `CHK(r, rg_pkg::RESP_SLVERR)
        wr(rg_pkg::IDX_STATUS, 32'h1); `CHK(r, rg_pkg::RESP_SLVERR)
        repeat (5) @(posedge clk);
        `CHK(dds_out, prof)
        wr(rg_pkg::IDX_LOWER, 32'h0); wr(rg_pkg::IDX_UPPER, 32'h400);
        wr(rg_pkg::IDX_RISE, 32'h40); wr(rg_pkg::IDX_FALL, 32'h20);
        wr(rg_pkg::IDX_RATE, {16'd2, 16'd3});
        wr(rg_pkg::IDX_CTRL, 32'h1);
        repeat (5) @(posedge clk);
        `CHK(dds_out, prof)
        upd(); repeat (10) @(posedge clk);
        `CHK(ramp_out, 32'h0)
        `CHK(dds_out, exp_dds(2'h0, 32'h0, prof))
        dir <= 1;
        step(); step();
        `CHK(gap, 48)
        `CHK(dlt, 32'h40)
        repeat (800) @(posedge clk);
        `CHK(ramp_out, 32'h400)
        wr(rg_pkg::IDX_UPPER, 32'h800);
        step(); `CHK(dlt, 32'h40)
        v = ramp_out; ce <= 0; repeat (200) @(posedge clk);
        `CHK(ramp_out, v)
        ce <= 1;
        hold <= 1; repeat (10) @(posedge clk);
        v = ramp_out; repeat (200) @(posedge clk);
        `CHK(ramp_out, v)
        // A high lower limit puts known upper bits on the frozen output
        v = {1'b1, r64[30:4], 4'h0};
        wr(rg_pkg::IDX_UPPER, 32'hffff_ffff); wr(rg_pkg::IDX_LOWER, v);
        for (int d = 0; d < 4; d++) begin
            wr(rg_pkg::IDX_CTRL, 32'h1 | (d << 4)); upd(); repeat (3) @(posedge clk);
            `CHK(dds_out, exp_dds(2'(d), v, prof))
        end
        `CHK(ramp_out, v)
        wr(rg_pkg::IDX_LOWER, 32'h0); wr(rg_pkg::IDX_UPPER, 32'h800);
        wr(rg_pkg::IDX_CTRL, 32'h1); upd();
        hold <= 0; dir <= 0;
        step(); step();
        `CHK(gap, 72)
        `CHK(dlt, 32'hffff_ffe0)
        wr(rg_pkg::IDX_LOWER, 32'h100); dir <= 1;
        repeat (1500) @(posedge clk);
        `CHK(ramp_out, 32'h800)
        wr(rg_pkg::IDX_CTRL, 32'h3); repeat (5) @(posedge clk);
        `CHK(ramp_out, 32'h800)
        upd(); repeat (200) @(posedge clk);
        `CHK(ramp_out, 32'h100)
        wr(rg_pkg::IDX_CTRL, 32'h5); upd(); repeat (400) @(posedge clk);
        `CHK(ramp_out > 32'h100, 1'b1)
        r64 = {$urandom, $urandom};
        prof_req <= r64[59:0];
        wr(rg_pkg::IDX_CTRL, 32'h0); upd(); repeat (10) @(posedge clk);
        `CHK(dds_out, prof)
        conclude();
    end
endmodule : tb
